/* File: include/dlbe_pkg.sv */
package dlbe_pkg;

    // Address decoration field positions
    localparam int SPACE_HI    = 30;       // Target space select, high bit
    localparam int SPACE_LO    = 29;       // Target space select, low bit
    localparam int OP_HI       = 28;       // Operation code, high bit
    localparam int OP_LO       = 26;       // Operation code, low bit
    localparam int BITPOS_HI   = 25;       // Single-bit position, high bit
    localparam int BITPOS_LO   = 21;       // Single-bit position, low bit
    localparam int FLDPOS_HI   = 27;       // Field start position, high bit
    localparam int FLDPOS_LO   = 23;       // Field start position, low bit
    localparam int FLDWID_HI   = 22;       // Field width code, high bit
    localparam int FLDWID_LO   = 19;       // Field width code, low bit
    localparam int EXTRACT_BIT = 28;       // Set for field extract
    localparam int OFFS_FULL_HI = 19;      // Offset top for single-bit ops
    localparam int OFFS_FLD_HI  = 18;      // Offset top for field extract

    // Space patterns and base addresses
    localparam logic [1:0]  SPACE_RAM    = 2'h1;          // Upper system RAM
    localparam logic [1:0]  SPACE_PERIPH = 2'h2;          // Peripheral region
    localparam logic [31:0] BASE_RAM     = 32'h2000_0000; // RAM base
    localparam logic [31:0] BASE_PERIPH  = 32'h4000_0000; // Peripheral base

    // Operation codes in address bits 28:26
    localparam logic [2:0] OP_CLEAR = 3'h2;   // Load and clear one bit
    localparam logic [2:0] OP_SET   = 3'h3;   // Load and set one bit

    // Transfer sizes as on the bus
    localparam logic [2:0] SIZE_BYTE = 3'h0;  // 8-bit container
    localparam logic [2:0] SIZE_HALF = 3'h1;  // 16-bit container
    localparam logic [2:0] SIZE_WORD = 3'h2;  // 32-bit container

    // Transfer types
    localparam logic [1:0] TRANS_IDLE   = 2'h0;  // No transfer
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;  // Single transfer

    // Decoded operation
    typedef enum logic [1:0] {
        DLBE_OP_NONE,
        DLBE_OP_CLEAR,
        DLBE_OP_SET,
        DLBE_OP_EXTRACT
    } dlbe_op_t;

    // Address phase of a bus transfer
    typedef struct packed {
        logic [31:0] addr;    // Byte address
        logic [1:0]  trans;   // Transfer type
        logic        write;   // High for write
        logic [2:0]  size;    // Transfer size
        logic [3:0]  prot;    // Protection attributes
    } dlbe_aphase_t;

endpackage : dlbe_pkg

/* File: hdl/dlbe_engine.sv */
`timescale 1ns/10ps
`default_nettype none

module dlbe_engine (
    input  wire logic                  sys_clk_i,     // System bus clock
    input  wire logic                  srst_i,        // Synchronous reset
    input  wire dlbe_pkg::dlbe_aphase_t m_aph_i,      // Core address phase
    input  wire logic [31:0]           m_wdata_i,     // Core write data
    output logic [31:0]                m_rdata_o,     // Read data to core
    output logic                       m_ready_o,     // Transfer done to core
    output logic                       m_resp_o,      // Error response to core
    output dlbe_pkg::dlbe_aphase_t     s_aph_o,       // Slave address phase
    output logic [31:0]                s_wdata_o,     // Slave write data
    input  wire logic [31:0]           s_rdata_i,     // Slave read data
    input  wire logic                  s_ready_i,     // Slave transfer done
    input  wire logic                  s_resp_i       // Slave error response
);

    // Sequencer states
    typedef enum logic [1:0] {
        DLBE_IDLE,       // Pass-through, no decorated transfer pending
        DLBE_READ,       // First data phase of a decorated load
        DLBE_FINISH      // Second data phase: return result, maybe write
    } dlbe_state_t;

    dlbe_state_t           state_r;      // Current state
    dlbe_state_t           state_nxt;    // Next state
    dlbe_pkg::dlbe_op_t    op_r;         // Captured operation
    dlbe_pkg::dlbe_op_t    op_dec;       // Operation decoded this cycle
    dlbe_pkg::dlbe_aphase_t cap_aph_r;   // Captured address and attributes
    logic [4:0]            pos_r;        // Captured bit or field position
    logic [3:0]            wid_r;        // Captured field width code
    logic [31:0]           mod_r;        // Registered modified or masked data
    logic                  bit_r;        // Registered extracted bit
    logic [31:0]           mask_w;       // Mask built in first data phase
    logic [31:0]           cmask_w;      // Container mask
    logic [31:0]           res_w;        // Result returned in finish phase
    logic                  m_take;       // Core address phase accepted
    logic                  decorated;    // Decorated load seen this cycle
    logic                  dphase_r;     // Pass-through data phase pending

    // Decode the decoration from a core address phase
    function automatic dlbe_pkg::dlbe_op_t dlbe_decode(input dlbe_pkg::dlbe_aphase_t a);
        logic [1:0] sp;
        sp = a.addr[dlbe_pkg::SPACE_HI:dlbe_pkg::SPACE_LO];
        dlbe_decode = dlbe_pkg::DLBE_OP_NONE;
        if (a.trans[1] && !a.write && !a.addr[31] &&
            (sp == dlbe_pkg::SPACE_RAM || sp == dlbe_pkg::SPACE_PERIPH)) begin
            if (a.addr[dlbe_pkg::EXTRACT_BIT]) begin
                dlbe_decode = dlbe_pkg::DLBE_OP_EXTRACT;
            end else if (a.addr[dlbe_pkg::OP_HI:dlbe_pkg::OP_LO] == dlbe_pkg::OP_CLEAR) begin
                dlbe_decode = dlbe_pkg::DLBE_OP_CLEAR;
            end else if (a.addr[dlbe_pkg::OP_HI:dlbe_pkg::OP_LO] == dlbe_pkg::OP_SET) begin
                dlbe_decode = dlbe_pkg::DLBE_OP_SET;
            end
        end
    endfunction : dlbe_decode

    // Strip decoration: rebuild the physical address in the chosen space
    function automatic logic [31:0] dlbe_strip(input logic [31:0] a, input logic fld);
        logic [31:0] base;
        logic [31:0] offs;
        base = (a[dlbe_pkg::SPACE_HI:dlbe_pkg::SPACE_LO] == dlbe_pkg::SPACE_RAM) ?
               dlbe_pkg::BASE_RAM : dlbe_pkg::BASE_PERIPH;
        if (fld) begin
            offs = {13'h0000, a[dlbe_pkg::OFFS_FLD_HI:0]};
        end else begin
            offs = {12'h000, a[dlbe_pkg::OFFS_FULL_HI:0]};
        end
        dlbe_strip = base | offs;
    endfunction : dlbe_strip

    // Container mask from the read size
    function automatic logic [31:0] dlbe_cont(input logic [2:0] size);
        case (size)
            dlbe_pkg::SIZE_BYTE: dlbe_cont = 32'h0000_00ff;
            dlbe_pkg::SIZE_HALF: dlbe_cont = 32'h0000_ffff;
            default:             dlbe_cont = 32'hffff_ffff;
        endcase
    endfunction : dlbe_cont

    assign m_take    = m_aph_i.trans[1] && m_ready_o;
    assign op_dec    = dlbe_decode(m_aph_i);
    assign decorated = m_take && (op_dec != dlbe_pkg::DLBE_OP_NONE);

    // Mask building: single bit or field, clipped to the container
    always_comb begin
        logic [32:0] wmask;
        wmask   = 33'h0;
        cmask_w = dlbe_cont(cap_aph_r.size);
        if (op_r == dlbe_pkg::DLBE_OP_EXTRACT) begin
            wmask  = (33'h1 << ({28'h0, wid_r} + 32'h1)) - 33'h1;
            mask_w = (wmask[31:0] << pos_r) & cmask_w;
        end else begin
            mask_w = (32'h1 << pos_r) & cmask_w;
        end
    end

    // Result for the core: bit or right-shifted field, zero-filled
    always_comb begin
        if (op_r == dlbe_pkg::DLBE_OP_EXTRACT) begin
            res_w = mod_r >> pos_r;
        end else begin
            res_w = {31'h0, bit_r};
        end
    end

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DLBE_IDLE: begin
                if (decorated) begin
                    state_nxt = DLBE_READ;
                end
            end
            DLBE_READ: begin
                if (s_ready_i) begin
                    state_nxt = DLBE_FINISH;
                end
            end
            DLBE_FINISH: begin
                // A decorated request taken in the last data phase starts at once
                if (s_ready_i) begin
                    state_nxt = decorated ? DLBE_READ : DLBE_IDLE;
                end
            end
            default: state_nxt = DLBE_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r <= DLBE_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Capture address, attributes and decoration at the first address phase
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cap_aph_r <= '0;
            op_r      <= dlbe_pkg::DLBE_OP_NONE;
            pos_r     <= 5'h00;
            wid_r     <= 4'h0;
        end else if (decorated) begin
            cap_aph_r      <= m_aph_i;
            cap_aph_r.addr <= dlbe_strip(m_aph_i.addr, op_dec == dlbe_pkg::DLBE_OP_EXTRACT);
            op_r           <= op_dec;
            if (op_dec == dlbe_pkg::DLBE_OP_EXTRACT) begin
                pos_r <= m_aph_i.addr[dlbe_pkg::FLDPOS_HI:dlbe_pkg::FLDPOS_LO];
                wid_r <= m_aph_i.addr[dlbe_pkg::FLDWID_HI:dlbe_pkg::FLDWID_LO];
            end else begin
                pos_r <= m_aph_i.addr[dlbe_pkg::BITPOS_HI:dlbe_pkg::BITPOS_LO];
                wid_r <= 4'h0;
            end
        end
    end

    // First data phase: read, modify and register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mod_r <= 32'h0;
            bit_r <= 1'b0;
        end else if (state_r == DLBE_READ && s_ready_i) begin
            bit_r <= |(s_rdata_i & mask_w);
            case (op_r)
                dlbe_pkg::DLBE_OP_CLEAR:   mod_r <= s_rdata_i & ~mask_w;
                dlbe_pkg::DLBE_OP_SET:     mod_r <= s_rdata_i | mask_w;
                dlbe_pkg::DLBE_OP_EXTRACT: mod_r <= s_rdata_i & mask_w;
                default:                   mod_r <= s_rdata_i;
            endcase
        end
    end

    // Pass-through data phase tracker for undecorated transfers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            dphase_r <= 1'b0;
        end else if (m_ready_o) begin
            dphase_r <= m_take && !decorated;
        end
    end

    // Slave address phase: forward, recirculate as write, or idle
    always_comb begin
        s_aph_o = m_aph_i;
        if (state_r == DLBE_READ) begin
            s_aph_o = cap_aph_r;
            if (op_r == dlbe_pkg::DLBE_OP_EXTRACT) begin
                s_aph_o.trans = dlbe_pkg::TRANS_IDLE;
            end else begin
                s_aph_o.write = 1'b1;
                s_aph_o.trans = dlbe_pkg::TRANS_NONSEQ;
            end
        end else if (decorated) begin    // Also a request taken in the finish phase
            s_aph_o.addr = dlbe_strip(m_aph_i.addr, op_dec == dlbe_pkg::DLBE_OP_EXTRACT);
        end
    end

    // Slave write data: registered modified data in the finish phase
    assign s_wdata_o = (state_r == DLBE_FINISH) ? mod_r : m_wdata_i;

    // Core side handshake and data
    always_comb begin
        case (state_r)
            DLBE_READ: begin
                m_ready_o = 1'b0;
                m_rdata_o = s_rdata_i;
                m_resp_o  = s_resp_i;
            end
            DLBE_FINISH: begin
                m_ready_o = s_ready_i;
                m_rdata_o = res_w;
                m_resp_o  = s_resp_i;
            end
            default: begin
                m_ready_o = dphase_r ? s_ready_i : 1'b1;
                m_rdata_o = s_rdata_i;
                m_resp_o  = dphase_r ? s_resp_i : 1'b0;
            end
        endcase
    end

    // Clear and set issue a write one cycle after the read
    property p_rmw_write;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r == DLBE_IDLE && decorated && op_dec != dlbe_pkg::DLBE_OP_EXTRACT)
        |=> (s_aph_o.write && s_aph_o.trans == dlbe_pkg::TRANS_NONSEQ);
    endproperty
    a_rmw_write: assert property (p_rmw_write) else $error("no write after bit op");

    // Extract never writes
    property p_no_extract_write;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r == DLBE_READ && op_r == dlbe_pkg::DLBE_OP_EXTRACT) |-> !s_aph_o.trans[1];
    endproperty
    a_no_extract_write: assert property (p_no_extract_write)
        else $error("extract drove slave");

    // Core stalled in first data phase
    property p_stall;
        @(posedge sys_clk_i) disable iff (srst_i)
        decorated |=> !m_ready_o;
    endproperty
    a_stall: assert property (p_stall) else $error("core not stalled");

    // Clear result has bit zero in written data
    property p_clear_data;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r == DLBE_READ && s_ready_i && op_r == dlbe_pkg::DLBE_OP_CLEAR)
        |=> ((s_wdata_o & (32'h1 << pos_r)) == 32'h0);
    endproperty
    a_clear_data: assert property (p_clear_data) else $error("bit not cleared");

    // Set result has bit one within container
    property p_set_data;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r == DLBE_READ && s_ready_i && op_r == dlbe_pkg::DLBE_OP_SET)
        |=> ((s_wdata_o & (32'h1 << pos_r) & cmask_w) == ((32'h1 << pos_r) & cmask_w));
    endproperty
    a_set_data: assert property (p_set_data) else $error("bit not set");

    // Single-bit results are zero-filled above bit zero
    property p_bit_zero_fill;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r == DLBE_FINISH && op_r != dlbe_pkg::DLBE_OP_EXTRACT)
        |-> (m_rdata_o[31:1] == 31'h0);
    endproperty
    a_bit_zero_fill: assert property (p_bit_zero_fill)
        else $error("bit result not zero-filled");

    // Extract result fits width code plus one
    property p_extract_width;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r == DLBE_FINISH && op_r == dlbe_pkg::DLBE_OP_EXTRACT)
        |-> ((33'(m_rdata_o) >> ({28'h0, wid_r} + 32'h1)) == 33'h0);
    endproperty
    a_extract_width: assert property (p_extract_width) else $error("field too wide");

    // Slave wait states hold the core
    property p_wait_pass;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r != DLBE_IDLE && !s_ready_i) |-> (!m_ready_o ##1 state_r == $past(state_r));
    endproperty
    a_wait_pass: assert property (p_wait_pass) else $error("wait state lost");

    // Extract leaves its second address phase idle
    property p_extract_idle;
        @(posedge sys_clk_i) disable iff (srst_i)
        (decorated && op_dec == dlbe_pkg::DLBE_OP_EXTRACT)
        |=> (s_aph_o.trans == dlbe_pkg::TRANS_IDLE);
    endproperty
    a_extract_idle: assert property (p_extract_idle)
        else $error("extract second phase not idle");

    // Decoration removed: base from the space bits, operation bits zeroed
    property p_strip_addr;
        @(posedge sys_clk_i) disable iff (srst_i)
        decorated |-> (s_aph_o.addr[31:29] == {1'b0, m_aph_i.addr[30:29]} &&
                       s_aph_o.addr[28:20] == 9'h000 && !s_aph_o.write);
    endproperty
    a_strip_addr: assert property (p_strip_addr)
        else $error("decorated address not stripped");

    // Extract drops address bit 19 from the offset
    property p_extract_offs;
        @(posedge sys_clk_i) disable iff (srst_i)
        (decorated && op_dec == dlbe_pkg::DLBE_OP_EXTRACT) |-> !s_aph_o.addr[19];
    endproperty
    a_extract_offs: assert property (p_extract_offs)
        else $error("extract kept bit 19 as address");

    // Undecorated requests reach the slave untouched
    property p_pass_through;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r == DLBE_IDLE && !decorated) |-> (s_aph_o == m_aph_i);
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("plain request altered");

    // Plain data phases end with the slave, no added stall
    property p_plain_ready;
        @(posedge sys_clk_i) disable iff (srst_i)
        (state_r == DLBE_IDLE && dphase_r) |-> (m_ready_o == s_ready_i);
    endproperty
    a_plain_ready: assert property (p_plain_ready)
        else $error("plain data phase stalled");

endmodule : dlbe_engine

`default_nettype wire

/* File: tb/dlbe_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Slave memory: pipelined address/data phases with optional wait states
module dlbe_mem_model (
    input  wire logic                   sys_clk_i,  // System clock
    input  wire logic                   srst_i,     // Synchronous reset
    input  wire dlbe_pkg::dlbe_aphase_t s_aph_i,    // Address phase from engine
    input  wire logic [31:0]            s_wdata_i,  // Write data from engine
    input  wire logic [1:0]             wait_i,     // Wait states per data phase
    output logic [31:0]                 rdata_o,    // Read data
    output logic                        ready_o,    // Data phase done
    output logic                        resp_o      // Error response
);
    logic [31:0] mem_r [16];  // Sixteen words, aliased over both spaces
    logic        pend_r;      // Data phase open
    logic        pwr_r;       // Open phase is a write
    logic [3:0]  pidx_r;      // Word index of open phase
    logic [31:0] pmask_r;     // Byte lanes of open write
    logic [1:0]  cnt_r;       // Wait states left
    logic [31:0] noise_r;     // Changing junk while data is not valid
    logic [31:0] lanes;       // Lanes of the incoming transfer

    // Byte lanes touched by the transfer size
    always_comb begin
        case (s_aph_i.size)
            dlbe_pkg::SIZE_BYTE: lanes = 32'h0000_00ff << {s_aph_i.addr[1:0], 3'h0};
            dlbe_pkg::SIZE_HALF: lanes = 32'h0000_ffff << {s_aph_i.addr[1], 4'h0};
            default:             lanes = 32'hffff_ffff;
        endcase
    end

    // Junk pattern so stale data never looks valid
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            noise_r <= 32'h0f0f_3c3c;
        end else begin
            noise_r <= {noise_r[30:0], ~noise_r[31]};
        end
    end

    // Phase pipeline: accept a new address only when the open phase ends
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pend_r <= 1'b0;
            cnt_r  <= 2'h0;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end else begin
            // Commit only the lanes that the size covers
            if (pend_r && pwr_r) begin
                mem_r[pidx_r] <= (mem_r[pidx_r] & ~pmask_r) | (s_wdata_i & pmask_r);
            end
            pend_r  <= s_aph_i.trans[1];
            pwr_r   <= s_aph_i.write;
            pidx_r  <= s_aph_i.addr[5:2];
            pmask_r <= lanes;
            cnt_r   <= s_aph_i.trans[1] ? wait_i : 2'h0;
        end
    end

    assign ready_o = (cnt_r == 2'h0);
    assign resp_o  = 1'b0;
    assign rdata_o = (ready_o && pend_r && !pwr_r) ? mem_r[pidx_r] : noise_r;
endmodule : dlbe_mem_model

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_errors++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end

module tb;
    logic                   sys_clk_i;   // Bench clock
    logic                   srst_i;      // Synchronous reset
    dlbe_pkg::dlbe_aphase_t m_aph_i;     // Core address phase
    logic [31:0]            m_wdata_i;   // Core write data
    logic [31:0]            m_rdata_o;   // Read data to core
    logic                   m_ready_o;   // Core transfer done
    logic                   m_resp_o;    // Core error response
    dlbe_pkg::dlbe_aphase_t s_aph_o;     // Slave address phase
    logic [31:0]            s_wdata_o;   // Slave write data
    logic [31:0]            s_rdata_i;   // Slave read data
    logic                   s_ready_i;   // Slave done
    logic                   s_resp_i;    // Slave error
    logic [1:0]             wait_n;      // Slave wait states
    int                     n_errors;    // Mismatches
    int                     checked;     // Comparisons
    int                     cycles;      // Timeout counter
    int                     seed;        // Random seed
    logic [31:0]            shadow [16]; // Expected memory
    logic [31:0]            exp_q [$];   // Expected read results
    logic [31:0]            exp_v;       // Oldest expected result
    logic                   dp_read;     // Core read data phase open

    dlbe_engine i_dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .m_aph_i(m_aph_i), .m_wdata_i(m_wdata_i),
        .m_rdata_o(m_rdata_o), .m_ready_o(m_ready_o), .m_resp_o(m_resp_o),
        .s_aph_o(s_aph_o), .s_wdata_o(s_wdata_o), .s_rdata_i(s_rdata_i),
        .s_ready_i(s_ready_i), .s_resp_i(s_resp_i)
    );

    dlbe_mem_model i_mem (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .s_aph_i(s_aph_o), .s_wdata_i(s_wdata_o),
        .wait_i(wait_n), .rdata_o(s_rdata_i), .ready_o(s_ready_i), .resp_o(s_resp_i)
    );

    // Clock generator
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // Verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // Cut a hang short
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end

    // Watcher: compare core read data with the oldest note
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            dp_read <= 1'b0;
        end else if (m_ready_o === 1'b1) begin
            if (dp_read) begin
                exp_v = exp_q.pop_front();
                `CHK("rdata", exp_v, m_rdata_o)
                `CHK("core_resp", 1'b0, m_resp_o)
            end
            dp_read <= m_aph_i.trans[1] && !m_aph_i.write;
        end
    end

    // One core transfer; kind 0 plain, 1 read-modify-write, 2 extract
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [2:0] sz,
                        input logic [31:0] wd, input logic [31:0] sa, input int kind,
                        input logic [31:0] rd);
        int n;
        int ex;
        repeat (2) @(negedge sys_clk_i);
        wait_n  = 2'({$random(seed)} % 3);
        m_aph_i = '{a, dlbe_pkg::TRANS_NONSEQ, wr, sz, 4'($random(seed))};
        #1;
        `CHK("slave_addr", sa, s_aph_o.addr)
        `CHK("slave_write", wr, s_aph_o.write)
        if (!wr) exp_q.push_back(rd);
        @(negedge sys_clk_i);
        m_aph_i.trans = dlbe_pkg::TRANS_IDLE;
        m_wdata_i     = wd;
        #1;
        // Second address phase depends on the operation
        if (kind == 1) begin
            `CHK("write_trans", dlbe_pkg::TRANS_NONSEQ, s_aph_o.trans)
            `CHK("write_dir", 1'b1, s_aph_o.write)
            `CHK("write_addr", sa, s_aph_o.addr)
        end else if (kind == 2) begin
            `CHK("idle_phase", dlbe_pkg::TRANS_IDLE, s_aph_o.trans)
        end
        n = 1;
        while (m_ready_o !== 1'b1 && n < 50) begin
            @(negedge sys_clk_i);
            #1;
            n++;
        end
        ex = (kind == 0) ? 1 + wait_n : (kind == 1) ? 2 + 2 * wait_n : 2 + wait_n;
        `CHK("data_cycles", ex, n)
        @(posedge sys_clk_i);
    endtask : xfer

    // One decorated load followed by a plain read of the touched word
    task automatic dec(input int op, input logic [1:0] sp, input logic [2:0] sz);
        logic [31:0] old;
        logic [31:0] cm;
        logic [31:0] off;
        logic [31:0] base;
        logic [4:0]  b;
        logic [3:0]  w;
        int          cw;
        int          idx;
        idx  = {$random(seed)} % 16;
        cw   = (sz == dlbe_pkg::SIZE_BYTE) ? 8 : (sz == dlbe_pkg::SIZE_HALF) ? 16 : 32;
        cm   = (cw == 32) ? 32'hffff_ffff : (32'h1 << cw) - 32'h1;
        b    = 5'({$random(seed)} % cw);
        w    = 4'($random(seed));
        base = (sp == dlbe_pkg::SPACE_RAM) ? dlbe_pkg::BASE_RAM : dlbe_pkg::BASE_PERIPH;
        old  = shadow[idx];
        if (op < 2) begin
            off = {12'h0, 1'($random(seed)), 13'h0, 4'(idx), 2'h0};
            shadow[idx] = (op == 0) ? old & ~(32'h1 << b) : old | (32'h1 << b);
            xfer({1'b0, sp, (op == 0) ? dlbe_pkg::OP_CLEAR : dlbe_pkg::OP_SET, b, 1'b0, off[19:0]},
                 1'b0, sz, 32'($random(seed)), base | off, 1, {31'h0, old[b]});
        end else begin
            off = {26'h0, 4'(idx), 2'h0};
            xfer({1'b0, sp, 1'b1, b, w, off[18:0]}, 1'b0, sz, 32'($random(seed)), base | off, 2,
                 ((old & cm) >> b) & ((32'h2 << w) - 32'h1));
        end
        xfer(base | off, 1'b0, dlbe_pkg::SIZE_WORD, 32'h0, base | off, 0, shadow[idx]);
    endtask : dec

    // Main sequence
    initial begin
        seed      = 32'he138;
        n_errors  = 0;
        checked   = 0;
        cycles    = 0;
        srst_i    = 1'b1;
        m_aph_i   = '0;
        m_wdata_i = 32'h0;
        wait_n    = 2'h0;
        repeat (16) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        srst_i = 1'b0;
        // Fill memory through plain writes
        for (int i = 0; i < 16; i++) begin
            shadow[i] = $random(seed);
            xfer(dlbe_pkg::BASE_RAM | 32'(i * 4), 1'b1, dlbe_pkg::SIZE_WORD, shadow[i],
                 dlbe_pkg::BASE_RAM | 32'(i * 4), 0, 32'h0);
        end
        $display("plain writes done");
        // Every operation, space and container size, twice
        for (int r = 0; r < 2; r++) begin
            for (int op = 0; op < 3; op++) begin
                for (int s = 0; s < 3; s++) begin
                    dec(op, dlbe_pkg::SPACE_RAM, 3'(s));
                    dec(op, dlbe_pkg::SPACE_PERIPH, 3'(s));
                end
            end
        end
        $display("decorated loads done");
        final_report();
    end
endmodule : tb

`default_nettype wire
